// file: inc/ppom_params.svh
`ifndef PPOM_PARAMS_SVH
`define PPOM_PARAMS_SVH

// Register offsets
`define PPOM_ADR_A_IN 8'h00
`define PPOM_ADR_A_DIR 8'h01
`define PPOM_ADR_A_DATA 8'h02
`define PPOM_ADR_B_IN 8'h03
`define PPOM_ADR_B_DIR 8'h04
`define PPOM_ADR_B_DATA 8'h05
`define PPOM_ADR_C_DIR 8'h07
`define PPOM_ADR_C_DATA 8'h08
`define PPOM_ADR_CTRL 8'h10
`define PPOM_ADR_PCMASK 8'h11
`define PPOM_ADR_ISTAT 8'h12
`define PPOM_ADR_IMASK 8'h13
`define PPOM_DS_OFS 8'h20

// Reset values
`define PPOM_RST_BYTE 8'h00

// Control fields
`define PPOM_PU_OFF_BIT 4
`define PPOM_PCGRP_BIT 0

// Port D alternate function bit positions
`define PPOM_PD_T2_CMPA 7
`define PPOM_PD_T2_CMPB 6
`define PPOM_PD_ICP 6
`define PPOM_PD_T1_CMPA 5
`define PPOM_PD_T1_CMPB 4
`define PPOM_PD_XCK 4
`define PPOM_PD_S2_TX 3
`define PPOM_PD_IRQ1 3
`define PPOM_PD_S2_RX 2
`define PPOM_PD_IRQ0 2
`define PPOM_PD_S1_TX 1
`define PPOM_PD_S1_RX 0
`define PPOM_PD_CNT3 0

`endif

// file: inc/ppom_pkg.sv
package ppom_pkg;

  typedef struct packed {
    logic [7:0] dir_a;
    logic [7:0] data_a;
    logic [7:0] in_a;
    logic [7:0] dir_b;
    logic [7:0] data_b;
    logic [7:0] in_b;
    logic [7:0] dir_c;
    logic [7:0] data_c;
    logic [7:0] in_d;
    logic [7:0] ctrl;
    logic [7:0] pcmask;
    logic [7:0] istat;
    logic [7:0] imask;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] out_a;
    logic [7:0] oe_a;
    logic [7:0] pu_a;
    logic [7:0] out_b;
    logic [7:0] oe_b;
    logic [7:0] pu_b;
    logic [7:0] out_c;
    logic [7:0] oe_c;
    logic [7:0] pu_c;
    logic [7:0] out_d;
    logic [7:0] oe_d;
    logic [7:0] pu_d;
    logic [7:0] din_keep;
    logic [7:0] pc_src;
    logic capture;
    logic s2_rx;
    logic s1_rx;
    logic s2_clk;
    logic irq0_in;
    logic irq1_in;
    logic cnt3_in;
  } ppom_state_t;

endpackage

// file: hdl/ppom_top.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "ppom_params.svh"

// What this block does
// - Timer2 compare B drives port D bit 6 only when its direction is output
// - Timer1 compare A drives port D bit 5 only when its direction is output
// - Timer1 compare B drives port D bit 4 only when its direction is output
// - Active compare enable replaces port D bits 7..4 output value with waveform
// - Port D bit 6 input feeds timer1 capture and pin change logic
// - Port D bit 4 direction selects serial2 clock out or in
// - Serial2 clock on port D bit 4 works only in synchronous mode
// - Serial2 transmit forces bit 3 output, no pull-up, transmit data
// - Serial1 transmit forces bit 1 output, no pull-up, transmit data
// - Serial2 receive forces bit 2 input; pull-up from data bit and disable
// - Serial1 receive forces bit 0 input; pull-up from data bit and disable
// - Bits 3 and 2 feed external interrupts one and zero, inputs kept on
// - Port D bit 0 is the timer3 count input
// - Each port D pin is a pin change source, input kept when enabled
// - Pull-up disable bit turns off every port pull-up
// - Data registers 8 bits, reset zero, at I/O and I/O plus 0x20
// - Direction registers 8 bits, reset zero, all pins start input
// - Input registers show sampled pin levels, reset zero
module ppom_top #(
  parameter int PORT_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_pullup,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pullup,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe,
  output logic [7:0] pc_pullup,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic [7:0] pd_oe,
  output logic [7:0] pd_pullup,
  input wire logic [7:0] portd_dir,
  input wire logic [7:0] portd_data,
  input wire logic timer2_compare_a_en,
  input wire logic timer2_compare_a_wave,
  input wire logic timer2_compare_b_en,
  input wire logic timer2_compare_b_wave,
  input wire logic timer1_compare_a_en,
  input wire logic timer1_compare_a_wave,
  input wire logic timer1_compare_b_en,
  input wire logic timer1_compare_b_wave,
  input wire logic serial2_sync_mode,
  input wire logic serial2_clock_drive,
  input wire logic serial2_tx_enable,
  input wire logic serial2_tx_line,
  input wire logic serial2_rx_enable,
  input wire logic serial1_tx_enable,
  input wire logic serial1_tx_line,
  input wire logic serial1_rx_enable,
  input wire logic ext_irq_zero_en,
  input wire logic ext_irq_one_en,
  output logic timer1_capture_input,
  output logic serial2_rx_line,
  output logic serial1_rx_line,
  output logic serial2_ext_clock,
  output logic ext_irq_zero,
  output logic ext_irq_one,
  output logic timer3_count_input,
  output logic [7:0] pin_change_src,
  output logic [7:0] portd_input_keep
);

  if (PORT_W != 8) begin : g_width_check
    $error("ppom_top serves 8-bit ports only");
  end

  ppom_pkg::ppom_state_t st;
  ppom_pkg::ppom_state_t next_st;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] io);
    return (a == io) || (a == 8'(io + `PPOM_DS_OFS));
  endfunction

  always_comb begin
    logic [7:0] pullup_override_enable;
    logic [7:0] pullup_override_value;
    logic [7:0] direction_override_enable;
    logic [7:0] direction_override_value;
    logic [7:0] value_override_enable;
    logic [7:0] value_override_value;
    logic [7:0] input_enable_override_enable;
    logic [7:0] dir_eff;
    logic [7:0] ev;
    logic [7:0] clr;
    logic pullup_disable_all;
    pullup_override_enable = 8'h00;
    pullup_override_value = 8'h00;
    direction_override_enable = 8'h00;
    direction_override_value = 8'h00;
    value_override_enable = 8'h00;
    value_override_value = 8'h00;
    input_enable_override_enable = 8'h00;
    dir_eff = 8'h00;
    ev = 8'h00;
    clr = 8'h00;
    next_st = st;
    pullup_disable_all = st.ctrl[`PPOM_PU_OFF_BIT];

    if (reg_wr && hit(reg_addr, `PPOM_ADR_A_DATA)) begin
      next_st.data_a = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `PPOM_ADR_B_DATA)) begin
      next_st.data_b = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `PPOM_ADR_C_DATA)) begin
      next_st.data_c = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `PPOM_ADR_A_DIR)) begin
      next_st.dir_a = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `PPOM_ADR_B_DIR)) begin
      next_st.dir_b = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, `PPOM_ADR_C_DIR)) begin
      next_st.dir_c = reg_wdata;
    end
    if (reg_wr && reg_addr == `PPOM_ADR_CTRL) begin
      next_st.ctrl = reg_wdata;
    end
    if (reg_wr && reg_addr == `PPOM_ADR_PCMASK) begin
      next_st.pcmask = reg_wdata;
    end
    if (reg_wr && reg_addr == `PPOM_ADR_IMASK) begin
      next_st.imask = reg_wdata;
    end
    if (reg_wr && reg_addr == `PPOM_ADR_ISTAT) begin
      clr = reg_wdata;
    end

    // Read data stands only in the cycle after the strobe
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      if (hit(reg_addr, `PPOM_ADR_A_IN)) begin
        next_st.rdata = st.in_a;
      end else if (hit(reg_addr, `PPOM_ADR_A_DIR)) begin
        next_st.rdata = st.dir_a;
      end else if (hit(reg_addr, `PPOM_ADR_A_DATA)) begin
        next_st.rdata = st.data_a;
      end else if (hit(reg_addr, `PPOM_ADR_B_IN)) begin
        next_st.rdata = st.in_b;
      end else if (hit(reg_addr, `PPOM_ADR_B_DIR)) begin
        next_st.rdata = st.dir_b;
      end else if (hit(reg_addr, `PPOM_ADR_B_DATA)) begin
        next_st.rdata = st.data_b;
      end else if (hit(reg_addr, `PPOM_ADR_C_DIR)) begin
        next_st.rdata = st.dir_c;
      end else if (hit(reg_addr, `PPOM_ADR_C_DATA)) begin
        next_st.rdata = st.data_c;
      end else if (reg_addr == `PPOM_ADR_CTRL) begin
        next_st.rdata = st.ctrl;
      end else if (reg_addr == `PPOM_ADR_PCMASK) begin
        next_st.rdata = st.pcmask;
      end else if (reg_addr == `PPOM_ADR_ISTAT) begin
        next_st.rdata = st.istat;
      end else if (reg_addr == `PPOM_ADR_IMASK) begin
        next_st.rdata = st.imask;
      end
    end

    next_st.in_a = pa_in;
    next_st.in_b = pb_in;
    next_st.in_d = pd_in;

    // Ports A to C: plain register control
    // global pull-up disable
    next_st.out_a = st.data_a;
    next_st.oe_a = st.dir_a;
    next_st.pu_a = st.data_a & ~st.dir_a & {8{~pullup_disable_all}};
    next_st.out_b = st.data_b;
    next_st.oe_b = st.dir_b;
    next_st.pu_b = st.data_b & ~st.dir_b & {8{~pullup_disable_all}};
    next_st.out_c = st.data_c;
    next_st.oe_c = st.dir_c;
    next_st.pu_c = st.data_c & ~st.dir_c & {8{~pullup_disable_all}};

    // compare outputs replace the value only, never the direction
    // timer2 compare B on bit 6
    // timer1 compare A on bit 5
    // timer1 compare B on bit 4
    value_override_enable[`PPOM_PD_T2_CMPA] = timer2_compare_a_en;
    value_override_value[`PPOM_PD_T2_CMPA] = timer2_compare_a_wave;
    value_override_enable[`PPOM_PD_T2_CMPB] = timer2_compare_b_en;
    value_override_value[`PPOM_PD_T2_CMPB] = timer2_compare_b_wave;
    value_override_enable[`PPOM_PD_T1_CMPA] = timer1_compare_a_en;
    value_override_value[`PPOM_PD_T1_CMPA] = timer1_compare_a_wave;
    // serial2 clock driven out when synchronous and output, unless timer1 compare B is enabled
    if (timer1_compare_b_en) begin
      value_override_enable[`PPOM_PD_T1_CMPB] = 1'b1;
      value_override_value[`PPOM_PD_T1_CMPB] = timer1_compare_b_wave;
    end else if (serial2_sync_mode && portd_dir[`PPOM_PD_XCK]) begin
      value_override_enable[`PPOM_PD_XCK] = 1'b1;
      value_override_value[`PPOM_PD_XCK] = serial2_clock_drive;
    end
    if (serial2_tx_enable) begin
      pullup_override_enable[`PPOM_PD_S2_TX] = 1'b1;
      direction_override_enable[`PPOM_PD_S2_TX] = 1'b1;
      direction_override_value[`PPOM_PD_S2_TX] = 1'b1;
      value_override_enable[`PPOM_PD_S2_TX] = 1'b1;
      value_override_value[`PPOM_PD_S2_TX] = serial2_tx_line;
    end
    if (serial2_rx_enable) begin
      pullup_override_enable[`PPOM_PD_S2_RX] = 1'b1;
      pullup_override_value[`PPOM_PD_S2_RX] = portd_data[`PPOM_PD_S2_RX] & ~pullup_disable_all;
      direction_override_enable[`PPOM_PD_S2_RX] = 1'b1;
    end
    if (serial1_tx_enable) begin
      pullup_override_enable[`PPOM_PD_S1_TX] = 1'b1;
      direction_override_enable[`PPOM_PD_S1_TX] = 1'b1;
      direction_override_value[`PPOM_PD_S1_TX] = 1'b1;
      value_override_enable[`PPOM_PD_S1_TX] = 1'b1;
      value_override_value[`PPOM_PD_S1_TX] = serial1_tx_line;
    end
    if (serial1_rx_enable) begin
      pullup_override_enable[`PPOM_PD_S1_RX] = 1'b1;
      pullup_override_value[`PPOM_PD_S1_RX] = portd_data[`PPOM_PD_S1_RX] & ~pullup_disable_all;
      direction_override_enable[`PPOM_PD_S1_RX] = 1'b1;
    end

    // per-pin mask with group enable keeps inputs on
    input_enable_override_enable = st.pcmask & {8{st.ctrl[`PPOM_PCGRP_BIT]}};
    input_enable_override_enable[`PPOM_PD_IRQ1] =
      input_enable_override_enable[`PPOM_PD_IRQ1] | ext_irq_one_en;
    input_enable_override_enable[`PPOM_PD_IRQ0] =
      input_enable_override_enable[`PPOM_PD_IRQ0] | ext_irq_zero_en;
    next_st.din_keep = input_enable_override_enable;

    for (int i = 0; i < 8; i++) begin
      dir_eff[i] = direction_override_enable[i] ? direction_override_value[i] : portd_dir[i];
      next_st.oe_d[i] = dir_eff[i];
      next_st.out_d[i] = value_override_enable[i] ? value_override_value[i] : portd_data[i];
      next_st.pu_d[i] = pullup_override_enable[i] ? pullup_override_value[i] :
        (portd_data[i] & ~portd_dir[i] & ~pullup_disable_all);
    end

    // Alternate inputs from sampled port D levels
    // capture input on bit 6
    next_st.capture = st.in_d[`PPOM_PD_ICP];
    next_st.s2_rx = st.in_d[`PPOM_PD_S2_RX];
    next_st.s1_rx = st.in_d[`PPOM_PD_S1_RX];
    // clock taken in when synchronous and input
    next_st.s2_clk = serial2_sync_mode & ~portd_dir[`PPOM_PD_XCK] & st.in_d[`PPOM_PD_XCK];
    next_st.irq1_in = st.in_d[`PPOM_PD_IRQ1];
    next_st.irq0_in = st.in_d[`PPOM_PD_IRQ0];
    next_st.cnt3_in = st.in_d[`PPOM_PD_CNT3];
    next_st.pc_src = st.in_d;

    // Pin change events set sticky status; set wins over clear
    // only masked pins of an enabled group raise status
    ev = (st.in_d ^ pd_in) & st.pcmask & {8{st.ctrl[`PPOM_PCGRP_BIT]}};
    next_st.istat = (st.istat & ~clr) | ev;
    next_st.irq = |(next_st.istat & next_st.imask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign irq = st.irq;
  assign pa_out = st.out_a;
  assign pa_oe = st.oe_a;
  assign pa_pullup = st.pu_a;
  assign pb_out = st.out_b;
  assign pb_oe = st.oe_b;
  assign pb_pullup = st.pu_b;
  assign pc_out = st.out_c;
  assign pc_oe = st.oe_c;
  assign pc_pullup = st.pu_c;
  assign pd_out = st.out_d;
  assign pd_oe = st.oe_d;
  assign pd_pullup = st.pu_d;
  assign timer1_capture_input = st.capture;
  assign serial2_rx_line = st.s2_rx;
  assign serial1_rx_line = st.s1_rx;
  assign serial2_ext_clock = st.s2_clk;
  assign ext_irq_zero = st.irq0_in;
  assign ext_irq_one = st.irq1_in;
  assign timer3_count_input = st.cnt3_in;
  assign pin_change_src = st.pc_src;
  assign portd_input_keep = st.din_keep;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_timer2_compare_b_wave_dir_kept: assert property (
    timer2_compare_b_en |=> pd_oe[`PPOM_PD_T2_CMPB] == $past(portd_dir[`PPOM_PD_T2_CMPB]))
    else $error("compare B changed bit 6 direction");
  chk_timer1_compare_a_wave_value: assert property (
    timer1_compare_a_en |=> pd_out[`PPOM_PD_T1_CMPA] == $past(timer1_compare_a_wave))
    else $error("bit 5 does not carry compare A");
  chk_timer1_compare_b_wave_dir_value: assert property (
    timer1_compare_b_en |=> pd_out[`PPOM_PD_T1_CMPB] == $past(timer1_compare_b_wave)
      && pd_oe[`PPOM_PD_T1_CMPB] == $past(portd_dir[`PPOM_PD_T1_CMPB]))
    else $error("bit 4 compare B wrong");
  chk_no_compare_data: assert property (
    !timer2_compare_a_en |=> pd_out[`PPOM_PD_T2_CMPA] == $past(portd_data[`PPOM_PD_T2_CMPA]))
    else $error("bit 7 not from data register");
  chk_capture_route: assert property (
    ##2 timer1_capture_input == $past(pd_in[`PPOM_PD_ICP], 2))
    else $error("capture input misrouted");
  chk_clock_input: assert property (
    !serial2_sync_mode |=> !serial2_ext_clock)
    else $error("serial2 clock active outside synchronous mode");
  chk_tx2_forced: assert property (
    serial2_tx_enable |=> pd_oe[`PPOM_PD_S2_TX] && !pd_pullup[`PPOM_PD_S2_TX]
      && pd_out[`PPOM_PD_S2_TX] == $past(serial2_tx_line))
    else $error("serial2 transmit pin not forced");
  chk_tx1_forced: assert property (
    serial1_tx_enable |=> pd_oe[`PPOM_PD_S1_TX] && !pd_pullup[`PPOM_PD_S1_TX]
      && pd_out[`PPOM_PD_S1_TX] == $past(serial1_tx_line))
    else $error("serial1 transmit pin not forced");
  chk_rx2_input: assert property (
    serial2_rx_enable |=> !pd_oe[`PPOM_PD_S2_RX] && pd_pullup[`PPOM_PD_S2_RX] ==
      ($past(portd_data[`PPOM_PD_S2_RX]) && !$past(st.ctrl[`PPOM_PU_OFF_BIT])))
    else $error("serial2 receive pin wrong");
  chk_rx1_input: assert property (
    serial1_rx_enable |=> !pd_oe[`PPOM_PD_S1_RX])
    else $error("serial1 receive pin not input");
  chk_keep_irq_pin: assert property (
    ext_irq_one_en |=> portd_input_keep[`PPOM_PD_IRQ1])
    else $error("interrupt one input not kept on");
  chk_pud_all_off: assert property (
    st.ctrl[`PPOM_PU_OFF_BIT] |=> pa_pullup == 8'h00 && pb_pullup == 8'h00 && pc_pullup == 8'h00)
    else $error("pull-up seen while disabled");
  chk_read_once: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  chk_irq_level: assert property (
    st.ctrl[`PPOM_PCGRP_BIT] && !reg_wr && |((st.in_d ^ pd_in) & st.pcmask & st.imask)
      |=> irq)
    else $error("pin change did not raise interrupt");

  cov_tx2: cover property (serial2_tx_enable ##1 pd_oe[`PPOM_PD_S2_TX]);
  cov_pwm: cover property (timer1_compare_a_en && portd_dir[`PPOM_PD_T1_CMPA]);
  cov_rx2_pullup: cover property (serial2_rx_enable && pd_pullup[`PPOM_PD_S2_RX]);
  cov_pc_irq: cover property ($rose(irq));
  cov_clr_set: cover property (reg_wr && reg_addr == `PPOM_ADR_ISTAT && |st.istat);

endmodule

// file: tb/ppom_board.sv
`timescale 1ns/1ps
// Board circuitry on ports A, B and D: pins driven by the device, by the
// board, by a pull-up, or left floating with a level that changes each cycle
module ppom_board (
  input wire logic clk,
  input wire logic [23:0] drv_val,
  input wire logic [23:0] drv_en,
  input wire logic [23:0] pull_en,
  input wire logic [23:0] ext_val,
  input wire logic [23:0] ext_en,
  output logic [23:0] pin_lvl
);
  logic flt;
  initial flt = 1'b0;
  always @(posedge clk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (drv_en[i]) pin_lvl[i] = drv_val[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pull_en[i]) pin_lvl[i] = 1'b1;
      else pin_lvl[i] = flt ^ i[0];
    end
  end
endmodule

// file: tb/ppom_top_test.sv
`timescale 1ns/1ps
`include "ppom_params.svh"
module ppom_top_test;
  logic clk, rst_n, reg_wr, reg_rd, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pa_in, pa_out, pa_oe, pa_pullup;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pullup, pc_out, pc_oe, pc_pullup;
  logic [7:0] pd_in, pd_out, pd_oe, pd_pullup, portd_dir, portd_data;
  logic [7:0] pin_change_src, portd_input_keep, ext_a, ext_d;
  logic [3:0] cmp_en, cmp_wave;
  logic serial2_sync_mode, serial2_clock_drive, serial2_tx_enable, serial2_tx_line;
  logic serial2_rx_enable, serial1_tx_enable, serial1_tx_line, serial1_rx_enable;
  logic ext_irq_zero_en, ext_irq_one_en, timer1_capture_input, serial2_rx_line;
  logic serial1_rx_line, serial2_ext_clock, ext_irq_zero, ext_irq_one;
  logic timer3_count_input;
  int n_mismatch, checks;

  ppom_top #(.PORT_W(8)) u_ppom_top (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .pa_in, .pa_out, .pa_oe, .pa_pullup, .pb_in, .pb_out, .pb_oe, .pb_pullup,
    .pc_out, .pc_oe, .pc_pullup, .pd_in, .pd_out, .pd_oe, .pd_pullup,
    .portd_dir, .portd_data,
    .timer2_compare_a_en(cmp_en[3]), .timer2_compare_a_wave(cmp_wave[3]),
    .timer2_compare_b_en(cmp_en[2]), .timer2_compare_b_wave(cmp_wave[2]),
    .timer1_compare_a_en(cmp_en[1]), .timer1_compare_a_wave(cmp_wave[1]),
    .timer1_compare_b_en(cmp_en[0]), .timer1_compare_b_wave(cmp_wave[0]),
    .serial2_sync_mode, .serial2_clock_drive, .serial2_tx_enable, .serial2_tx_line,
    .serial2_rx_enable, .serial1_tx_enable, .serial1_tx_line, .serial1_rx_enable,
    .ext_irq_zero_en, .ext_irq_one_en, .timer1_capture_input, .serial2_rx_line,
    .serial1_rx_line, .serial2_ext_clock, .ext_irq_zero, .ext_irq_one,
    .timer3_count_input, .pin_change_src, .portd_input_keep
  );

  ppom_board u_ppom_board (
    .clk(clk),
    .drv_val({pd_out, pb_out, pa_out}),
    .drv_en({pd_oe, pb_oe, pa_oe}),
    .pull_en({pd_pullup, pb_pullup, pa_pullup}),
    .ext_val({ext_d, 8'h00, ext_a}),
    .ext_en({8'hFF, 8'h00, 8'hF0}),
    .pin_lvl({pd_in, pb_in, pa_in})
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic complete_run;
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] ins();
    return {timer1_capture_input, ext_irq_one, ext_irq_zero, serial2_rx_line,
            serial1_rx_line, timer3_count_input, 2'b00};
  endfunction

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    logic [7:0] adr [6];
    adr = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h08};
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, portd_dir, portd_data} = '0;
    {ext_a, ext_d, cmp_en, cmp_wave, serial2_sync_mode, serial2_clock_drive} = '0;
    {serial2_tx_enable, serial2_tx_line, serial2_rx_enable, serial1_tx_enable} = '0;
    {serial1_tx_line, serial1_rx_enable, ext_irq_zero_en, ext_irq_one_en} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rdc(adr[i], 8'h00);
    chk(pa_oe, 8'h00);
    wr(`PPOM_ADR_A_DATA, 8'hA5);
    wr(`PPOM_ADR_A_DIR + `PPOM_DS_OFS, 8'h0F);
    ext_a <= 8'h50;
    rdc(`PPOM_ADR_A_DATA + `PPOM_DS_OFS, 8'hA5);
    rdc(`PPOM_ADR_A_DIR, 8'h0F);
    settle();
    chk(pa_oe, 8'h0F);
    chk(pa_out & pa_oe, 8'h05);
    chk(pa_pullup, 8'hA0);
    wr(`PPOM_ADR_A_IN, 8'hFF);
    rdc(`PPOM_ADR_A_IN + `PPOM_DS_OFS, 8'h55);
    wr(`PPOM_ADR_CTRL, 8'h10);
    settle();
    chk(pa_pullup, 8'h00);
    wr(`PPOM_ADR_CTRL, 8'h00);
    wr(`PPOM_ADR_B_DATA, 8'h3C);
    wr(`PPOM_ADR_B_DIR + `PPOM_DS_OFS, 8'hFF);
    wr(`PPOM_ADR_C_DATA + `PPOM_DS_OFS, 8'h81);
    wr(`PPOM_ADR_C_DIR, 8'h01);
    settle();
    rdc(`PPOM_ADR_B_IN, 8'h3C);
    chk(pb_out, 8'h3C);
    chk(pb_oe, 8'hFF);
    chk(pb_pullup, 8'h00);
    chk(pc_out, 8'h81);
    chk(pc_pullup, 8'h80);
    chk(pc_oe, 8'h01);
    rdc(8'h3F, 8'h00);
    cmp_en <= 4'hF;
    cmp_wave <= 4'hA;
    portd_data <= 8'h50;
    settle();
    chk(pd_oe & 8'hF0, 8'h00);
    portd_dir <= 8'hF0;
    settle();
    chk(pd_oe & 8'hF0, 8'hF0);
    chk(pd_out & 8'hF0, 8'hA0);
    cmp_en <= 4'h0;
    settle();
    chk(pd_out & 8'hF0, 8'h50);
    portd_dir <= 8'h00;
    portd_data <= 8'h0A;
    {serial2_tx_enable, serial2_tx_line, serial1_tx_enable, serial1_tx_line} <= 4'hE;
    settle();
    chk(pd_oe & 8'h0A, 8'h0A);
    chk(pd_pullup & 8'h0A, 8'h00);
    chk(pd_out & 8'h0A, 8'h08);
    {serial2_tx_enable, serial1_tx_enable} <= 2'b00;
    settle();
    chk(pd_pullup & 8'h0A, 8'h0A);
    portd_dir <= 8'h05;
    portd_data <= 8'h05;
    {serial2_rx_enable, serial1_rx_enable} <= 2'b11;
    settle();
    chk(pd_oe & 8'h05, 8'h00);
    chk(pd_pullup & 8'h05, 8'h05);
    wr(`PPOM_ADR_CTRL, 8'h10);
    settle();
    chk(pd_pullup, 8'h00);
    wr(`PPOM_ADR_CTRL, 8'h00);
    portd_dir <= 8'h00;
    portd_data <= 8'h00;
    ext_d <= 8'h45;
    settle();
    chk(pin_change_src, 8'h45);
    chk(ins(), 8'hBC);
    ext_d <= 8'hBA;
    settle();
    chk(ins(), 8'h40);
    serial2_sync_mode <= 1'b1;
    settle();
    chk({7'h00, serial2_ext_clock}, 8'h01);
    serial2_sync_mode <= 1'b0;
    settle();
    chk({7'h00, serial2_ext_clock}, 8'h00);
    serial2_sync_mode <= 1'b1;
    serial2_clock_drive <= 1'b1;
    portd_dir <= 8'h10;
    settle();
    chk(pd_oe & pd_out & 8'h10, 8'h10);
    chk({7'h00, serial2_ext_clock}, 8'h00);
    {serial2_sync_mode, serial2_clock_drive} <= 2'b00;
    portd_dir <= 8'h00;
    ext_irq_one_en <= 1'b1;
    wr(`PPOM_ADR_PCMASK, 8'h40);
    wr(`PPOM_ADR_CTRL, 8'h01);
    settle();
    chk(portd_input_keep, 8'h48);
    wr(`PPOM_ADR_CTRL, 8'h00);
    settle();
    chk(portd_input_keep, 8'h08);
    wr(`PPOM_ADR_PCMASK, 8'hFF);
    wr(`PPOM_ADR_IMASK, 8'h20);
    wr(`PPOM_ADR_CTRL, 8'h01);
    wr(`PPOM_ADR_ISTAT, 8'hFF);
    settle();
    chk({7'h00, irq}, 8'h00);
    ext_d <= 8'h9B;
    settle();
    chk({7'h00, irq}, 8'h01);
    rdc(`PPOM_ADR_ISTAT, 8'h21);
    wr(`PPOM_ADR_ISTAT, 8'h20);
    settle();
    chk({7'h00, irq}, 8'h00);
    wr(`PPOM_ADR_IMASK, 8'h01);
    settle();
    chk({7'h00, irq}, 8'h01);
    wr(`PPOM_ADR_ISTAT, 8'h01);
    settle();
    chk({7'h00, irq}, 8'h00);
    complete_run();
  end
endmodule
